// ### rtl/cfmx_fanout.sv
// clock fan-out: two-way source select, synchronous gate, five true/complement output pairs
// What this block does
// - low select takes differential, high takes single-ended
// - chosen clock copied to all five pairs
// - gate input registered; registered value gates outputs
// - gate low: outputs start at next falling edge
// - gate high: outputs forced low at falling edge
// - outputs switch on or off only while low
// - open differential input reads as steady low
// - each pair carries true and complement lines
`timescale 1ns/1ps
`default_nettype none

module cfmx_fanout #(
    parameter int N_OUT = cfmx_pkg::NUM_OUTPUTS
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      diff_clk_p,
    input  wire logic                      diff_clk_n,
    input  wire logic                      diff_open,
    input  wire logic                      single_ended_clock_in,
    input  wire logic                      source_choice,
    input  wire logic                      output_gate_n,
    output cfmx_pkg::cfmx_diff_t [N_OUT-1:0] buffered_outputs,
    output logic                           outputs_active
);
    // the clock inputs are sampled on core_clk; fast enough sources are out of scope
    logic [1:0] sync_p_q, sync_n_q, sync_s_q, sync_sel_q, sync_en_q, sync_open_q;
    logic       chosen_q;
    logic       gate_q;
    cfmx_pkg::cfmx_state_t state_q, state_d;
    cfmx_pkg::cfmx_diff_t [N_OUT-1:0] out_q, out_d;
    logic       act_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_p_q   <= cfmx_pkg::SYNC_RST;
            sync_n_q   <= cfmx_pkg::SYNC_RST;
            sync_s_q   <= cfmx_pkg::SYNC_RST;
            sync_sel_q <= cfmx_pkg::SYNC_RST;
            sync_en_q  <= {2{cfmx_pkg::GATE_SHUT_N}};
            sync_open_q <= cfmx_pkg::SYNC_RST;
        end else begin
            sync_p_q   <= {sync_p_q[0], diff_clk_p};
            sync_n_q   <= {sync_n_q[0], diff_clk_n};
            sync_s_q   <= {sync_s_q[0], single_ended_clock_in};
            sync_sel_q <= {sync_sel_q[0], source_choice};
            sync_en_q  <= {sync_en_q[0], output_gate_n};
            // the open-pin flag is a pin level too, so it is synchronised like the rest
            sync_open_q <= {sync_open_q[0], diff_open};
        end
    end

    // open pins bias to differential low, so an open pair never clocks
    wire diff_level = !sync_open_q[1] && sync_p_q[1] && !sync_n_q[1];
    wire chosen_d   = (sync_sel_q[1] == cfmx_pkg::SEL_SINGLE) ? sync_s_q[1]
                                                               : diff_level;
    wire fall_edge  = chosen_q && !chosen_d;
    wire gate_d     = fall_edge ? sync_en_q[1] : gate_q;

    // the pass state changes only on a falling edge, when the chosen clock is low
    // it reads the registered gate, so a gate change between edges just waits
    always_comb begin
        state_d = state_q;
        case (state_q)
            cfmx_pkg::CFMX_IDLE: begin
                if (fall_edge && gate_d == cfmx_pkg::GATE_OPEN_N) begin
                    state_d = cfmx_pkg::CFMX_PASS;
                end
            end
            cfmx_pkg::CFMX_PASS: begin
                if (fall_edge && gate_d == cfmx_pkg::GATE_SHUT_N) begin
                    state_d = cfmx_pkg::CFMX_IDLE;
                end
            end
            default: begin
                state_d = cfmx_pkg::CFMX_IDLE;
            end
        endcase
    end

    wire pass_now = (state_d == cfmx_pkg::CFMX_PASS);
    wire level    = pass_now ? chosen_d : cfmx_pkg::OUT_LOW;

    // one pair: true copy above, complement below; reset and live path share it
    function automatic cfmx_pkg::cfmx_diff_t pair_of(input logic lvl);
        cfmx_pkg::cfmx_diff_t pair;
        pair.true_line = lvl;
        pair.comp_line = !lvl;
        return pair;
    endfunction : pair_of

    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            out_d[i] = pair_of(level);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chosen_q <= cfmx_pkg::OUT_LOW;
            gate_q   <= cfmx_pkg::GATE_SHUT_N;
            state_q  <= cfmx_pkg::CFMX_IDLE;
            out_q    <= {N_OUT{pair_of(cfmx_pkg::OUT_LOW)}};
            act_q    <= cfmx_pkg::ACT_RST;
        end else begin
            chosen_q <= chosen_d;
            gate_q   <= gate_d;
            state_q  <= state_d;
            out_q    <= out_d;
            act_q    <= pass_now;
        end
    end

    assign buffered_outputs = out_q;
    assign outputs_active   = act_q;

    // outputs idle until a falling edge clocks in a low gate
    property p_start_on_fall;
        @(posedge core_clk) disable iff (!rst_n)
            (fall_edge && !sync_en_q[1])
            |=> act_q;
    endproperty
    a_start_on_fall: assert property (p_start_on_fall) else $error("no start");

    property p_stop_on_fall;
        @(posedge core_clk) disable iff (!rst_n)
            (fall_edge && sync_en_q[1])
            |=> (!act_q && !out_q[0].true_line);
    endproperty
    a_stop_on_fall: assert property (p_stop_on_fall) else $error("no stop");

    property p_low_start;
        @(posedge core_clk) disable iff (!rst_n)
            $rose(act_q)
            |-> !out_q[0].true_line && !$past(out_q[0].true_line);
    endproperty
    a_low_start: assert property (p_low_start) else $error("runt at start");

    property p_low_stop;
        @(posedge core_clk) disable iff (!rst_n)
            $fell(act_q)
            |-> !out_q[0].true_line && !chosen_q;
    endproperty
    a_low_stop: assert property (p_low_stop) else $error("runt at stop");

    property p_rise_when_active;
        @(posedge core_clk) disable iff (!rst_n)
            $rose(out_q[0].true_line)
            |-> act_q && $past(act_q);
    endproperty
    a_rise_when_active: assert property (p_rise_when_active) else $error("early rise");

    property p_gate_hold;
        @(posedge core_clk) disable iff (!rst_n)
            !fall_edge
            |=> $stable(gate_q);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate moved");

    property p_gate_take;
        @(posedge core_clk) disable iff (!rst_n)
            fall_edge
            |=> gate_q == $past(sync_en_q[1]);
    endproperty
    a_gate_take: assert property (p_gate_take) else $error("gate not taken");

    property p_gate_rules;
        @(posedge core_clk) disable iff (!rst_n)
            (state_q == cfmx_pkg::CFMX_PASS) == (gate_q == cfmx_pkg::GATE_OPEN_N);
    endproperty
    a_gate_rules: assert property (p_gate_rules) else $error("raw gate used");

    property p_all_same;
        @(posedge core_clk) disable iff (!rst_n)
            out_q == {N_OUT{out_q[0]}};
    endproperty
    a_all_same: assert property (p_all_same) else $error("pairs differ");

    property p_compl;
        @(posedge core_clk) disable iff (!rst_n)
            out_q[0].comp_line == !out_q[0].true_line;
    endproperty
    a_compl: assert property (p_compl) else $error("not complement");

    property p_follow;
        @(posedge core_clk) disable iff (!rst_n)
            (state_q == cfmx_pkg::CFMX_PASS && !fall_edge)
            |=> out_q[0].true_line == $past(chosen_d);
    endproperty
    a_follow: assert property (p_follow) else $error("not following");

    property p_single_route;
        @(posedge core_clk) disable iff (!rst_n)
            (state_q == cfmx_pkg::CFMX_PASS && !fall_edge && sync_sel_q[1] == cfmx_pkg::SEL_SINGLE)
            |=> out_q[0].true_line == $past(sync_s_q[1]);
    endproperty
    a_single_route: assert property (p_single_route) else $error("single not routed");

    property p_diff_route;
        @(posedge core_clk) disable iff (!rst_n)
            (state_q == cfmx_pkg::CFMX_PASS && !fall_edge && sync_sel_q[1] == cfmx_pkg::SEL_DIFF)
            |=> out_q[0].true_line == $past(diff_level);
    endproperty
    a_diff_route: assert property (p_diff_route) else $error("diff not routed");

    property p_open_low;
        @(posedge core_clk) disable iff (!rst_n)
            (sync_open_q[1] && sync_sel_q[1] == cfmx_pkg::SEL_DIFF)
            |=> !chosen_q;
    endproperty
    a_open_low: assert property (p_open_low) else $error("open not low");

    property p_idle_low;
        @(posedge core_clk) disable iff (!rst_n)
            (state_q == cfmx_pkg::CFMX_IDLE)
            |-> !out_q[0].true_line && !act_q;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle not low");

    property p_no_start_idle;
        @(posedge core_clk) disable iff (!rst_n)
            (state_q == cfmx_pkg::CFMX_IDLE && !fall_edge)
            |=> !act_q;
    endproperty
    a_no_start_idle: assert property (p_no_start_idle) else $error("start without edge");

    // main scenarios: start, stop, each source, open differential pins
    c_start: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(act_q));
    c_stop:  cover property (@(posedge core_clk) disable iff (!rst_n) $fell(act_q));
    c_single: cover property (@(posedge core_clk) disable iff (!rst_n)
        act_q && sync_sel_q[1] && out_q[0].true_line);
    c_diff: cover property (@(posedge core_clk) disable iff (!rst_n)
        act_q && !sync_sel_q[1] && out_q[0].true_line);
    c_open: cover property (@(posedge core_clk) disable iff (!rst_n)
        act_q && !sync_sel_q[1] && sync_open_q[1]);
endmodule : cfmx_fanout

`default_nettype wire

// ### shared/cfmx_pkg.sv
// package for the clock fan-out block: widths, encodings, carried pin groups
package cfmx_pkg;
    localparam int   NUM_OUTPUTS    = 5;
    localparam logic SEL_DIFF       = 1'h0;
    localparam logic SEL_SINGLE     = 1'h1;
    localparam logic GATE_OPEN_N    = 1'h0;
    localparam logic GATE_SHUT_N    = 1'h1;
    localparam logic OUT_LOW        = 1'h0;
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic ACT_RST        = 1'h0;

    typedef struct packed {
        logic true_line;
        logic comp_line;
    } cfmx_diff_t;

    typedef enum {
        CFMX_IDLE,
        CFMX_PASS
    } cfmx_state_t;
endpackage : cfmx_pkg

// ### test/cfmx_clk_src.sv
// clock source model feeding both fan-out inputs
`timescale 1ns/1ps
`default_nettype none
module cfmx_clk_src (
    output logic      diff_clk_p,
    output logic      diff_clk_n,
    output logic      single_ended_clock_in,
    input  wire logic core_clk
);
    logic diff_lvl = 1'b0;
    logic se_lvl   = 1'b0;
    assign diff_clk_p            = diff_lvl;
    assign diff_clk_n            = ~diff_lvl;
    assign single_ended_clock_in = se_lvl;
    // slow edges: each level held 8 cycles so the oversampler sees it
    task automatic drive(input logic which, input logic lvl);
        if (which) se_lvl = lvl; else diff_lvl = lvl;
        repeat (8) @(negedge core_clk);
    endtask : drive
endmodule : cfmx_clk_src
`default_nettype wire

// ### test/cfmx_fanout_bench.sv
// self-checking bench for the clock fan-out block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module cfmx_fanout_bench;
    logic core_clk      = 1'b0;
    logic rst_n         = 1'b0;
    logic diff_open     = 1'b0;
    logic source_choice = cfmx_pkg::SEL_DIFF;
    logic output_gate_n = cfmx_pkg::GATE_SHUT_N;
    logic diff_clk_p, diff_clk_n, single_ended_clock_in, outputs_active;
    cfmx_pkg::cfmx_diff_t [cfmx_pkg::NUM_OUTPUTS-1:0] buffered_outputs;
    int   miscompares   = 0;
    int   compares      = 0;
    always #12.5 core_clk = ~core_clk;
    cfmx_clk_src cfmx_clk_src_inst (.diff_clk_p(diff_clk_p), .diff_clk_n(diff_clk_n),
        .single_ended_clock_in(single_ended_clock_in), .core_clk(core_clk));
    cfmx_fanout #(.N_OUT(cfmx_pkg::NUM_OUTPUTS)) cfmx_fanout_inst (.core_clk(core_clk),
        .rst_n(rst_n), .diff_clk_p(diff_clk_p), .diff_clk_n(diff_clk_n), .diff_open(diff_open),
        .single_ended_clock_in(single_ended_clock_in), .source_choice(source_choice),
        .output_gate_n(output_gate_n), .buffered_outputs(buffered_outputs),
        .outputs_active(outputs_active));
    // every pair carries the level on true_line and its inverse on comp_line
    function automatic logic [9:0] pairs(input logic t);
        return {cfmx_pkg::NUM_OUTPUTS{t, ~t}};
    endfunction : pairs
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic t_enable();
        `CHK("idle outs", pairs(1'b0), buffered_outputs)
        output_gate_n = cfmx_pkg::GATE_OPEN_N;
        cfmx_clk_src_inst.drive(1'b0, 1'b1);
        `CHK("active before fall", 1'b0, outputs_active)
        cfmx_clk_src_inst.drive(1'b0, 1'b0);
        `CHK("active after fall", 1'b1, outputs_active)
        cfmx_clk_src_inst.drive(1'b0, 1'b1);
        `CHK("diff high", pairs(1'b1), buffered_outputs)
    endtask : t_enable
    task automatic t_select();
        source_choice = cfmx_pkg::SEL_SINGLE;
        cfmx_clk_src_inst.drive(1'b1, 1'b1);
        `CHK("single high", pairs(1'b1), buffered_outputs)
        cfmx_clk_src_inst.drive(1'b0, 1'b0);
        `CHK("diff ignored", pairs(1'b1), buffered_outputs)
        cfmx_clk_src_inst.drive(1'b1, 1'b0);
        `CHK("single low", pairs(1'b0), buffered_outputs)
    endtask : t_select
    task automatic t_disable();
        cfmx_clk_src_inst.drive(1'b1, 1'b1);
        output_gate_n = cfmx_pkg::GATE_SHUT_N;
        repeat (8) @(negedge core_clk);
        `CHK("no runt", pairs(1'b1), buffered_outputs)
        cfmx_clk_src_inst.drive(1'b1, 1'b0);
        `CHK("stopped", 1'b0, outputs_active)
        cfmx_clk_src_inst.drive(1'b1, 1'b1);
        `CHK("held low", pairs(1'b0), buffered_outputs)
    endtask : t_disable
    task automatic t_open();
        source_choice = cfmx_pkg::SEL_DIFF;
        output_gate_n = cfmx_pkg::GATE_OPEN_N;
        cfmx_clk_src_inst.drive(1'b0, 1'b1);
        cfmx_clk_src_inst.drive(1'b0, 1'b0);
        cfmx_clk_src_inst.drive(1'b0, 1'b1);
        `CHK("diff again", pairs(1'b1), buffered_outputs)
        diff_open = 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK("open reads low", pairs(1'b0), buffered_outputs)
    endtask : t_open
    initial begin
        #50000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_enable();
        t_select();
        t_disable();
        t_open();
        report_and_stop();
    end
endmodule : cfmx_fanout_bench
`default_nettype wire
